// ==== design/nand_host_pkg.sv ====
package nand_host_pkg;
  // device command bytes
  localparam logic [7:0] CMD_READ1  = 8'h00;
  localparam logic [7:0] CMD_READ2  = 8'h30;
  localparam logic [7:0] CMD_PROG1  = 8'h80;
  localparam logic [7:0] CMD_PROG2  = 8'h10;
  localparam logic [7:0] CMD_ERASE1 = 8'h60;
  localparam logic [7:0] CMD_ERASE2 = 8'hD0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] BAD_MARK   = 8'h00;
  localparam logic [7:0] FILL_BYTE  = 8'hFF;
  localparam int         STAT_FAIL_BIT = 0;
  // geometry
  localparam int BLOCKS     = 1024;
  localparam int MIN_GOOD   = 1004;
  localparam int PAGES      = 64;
  localparam int PAGE_BYTES = 2176;
  localparam int MARK_COL   = 2048;
  localparam int MAX_PARTIAL = 4;
  localparam int ADDR_PAGE  = 4;
  localparam int ADDR_ERASE = 2;
  // correction strength and rewrite warning level
  localparam int ECC_MAX_BITS = 8;
  localparam int ECC_SECTOR   = 512;
  localparam int ECC_WARN     = 6;
  // timing
  localparam int CLK_NS     = 8;
  localparam int STROBE_NS  = 25;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int TWB_NS     = 100;
  localparam int TWB_TICKS  = (TWB_NS + STROBE_NS - 1) / STROBE_NS;
  typedef enum logic [1:0] {OP_READ = 2'h0, OP_PROG = 2'h1, OP_ERASE = 2'h2, OP_SCAN = 2'h3} op_e;
endpackage

// ==== design/bbt_if.sv ====
`timescale 1ns/1ps
interface bbt_if;
  logic [9:0]  chk_blk;
  logic        chk_bad;
  logic        mark;
  logic [9:0]  mark_blk;
  logic        spare_req;
  logic [9:0]  spare_blk;
  logic        spare_ok;
  logic [10:0] bad_cnt;
  modport user  (output chk_blk, mark, mark_blk, spare_req,
                 input chk_bad, spare_blk, spare_ok, bad_cnt);
  modport store (input chk_blk, mark, mark_blk, spare_req,
                 output chk_bad, spare_blk, spare_ok, bad_cnt);
endinterface

// ==== design/strobe_divider.sv ====
`timescale 1ns/1ps
module strobe_divider #(
  parameter int DIV = nand_host_pkg::STROBE_CYC
) (
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  output logic      o_tick
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       tick_q;
  logic       tick_d;
  always_comb begin
    tick_d = (cnt_q == 8'(DIV - 1));
    cnt_d  = tick_d ? 8'h00 : cnt_q + 8'h01;
  end
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      cnt_q  <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end
  assign o_tick = tick_q;
endmodule // strobe_divider

// ==== design/bad_block_table.sv ====
`timescale 1ns/1ps
module bad_block_table #(
  parameter int NBLK = nand_host_pkg::BLOCKS
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  bbt_if.store     bbt
);
  logic [NBLK-1:0] bad_q;
  logic [NBLK-1:0] bad_d;
  logic [10:0]     cnt_q;
  logic [10:0]     cnt_d;
  logic [9:0]      ptr_q;
  logic [9:0]      ptr_d;
  always_comb begin
    bad_d = bad_q;
    cnt_d = cnt_q;
    // once marked, a block never leaves the table
    if (bbt.mark && !bad_q[bbt.mark_blk]) begin
      bad_d[bbt.mark_blk] = 1'b1;
      cnt_d = cnt_q + 11'h001;
    end
    // rotating spare pointer spreads wear
    ptr_d = (bbt.spare_req || bad_q[ptr_q]) ? ptr_q + 10'h001 : ptr_q;
  end
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      bad_q <= '0;
      cnt_q <= 11'h000;
      ptr_q <= 10'h000;
    end else begin
      bad_q <= bad_d;
      cnt_q <= cnt_d;
      ptr_q <= ptr_d;
    end
  end
  assign bbt.chk_bad   = bad_q[bbt.chk_blk];
  assign bbt.spare_blk = ptr_q;
  assign bbt.spare_ok  = !bad_q[ptr_q];
  assign bbt.bad_cnt   = cnt_q;
endmodule // bad_block_table

// ==== design/nand_host_ctrl.sv ====
`timescale 1ns/1ps
// Contract
// - at most 4 partial programs go to one page before its block is erased; the code counts them in the open block only.
// - a block whose marker column reads 00h is classed as bad.
// - no erase is ever issued to a block known to be bad.
// - each erase is followed by a status read and a failing block is retired.
// - a failing program retires the block and offers a spare block.
// - correction status for 8 bits per 512 bytes is watched for rewrite.
// - block management keeps working with as few as 1004 good blocks of 1024.
// - only program or erase status failures and scans reading 00h mark a block bad.
// - the unused rest of a page is programmed with ones.
// - erase and program load is spread over all blocks; the code only rotates the spare block it offers.
// - after command 70h each read strobe returns status, bit zero low for pass.
// - pages inside a block are programmed in ascending order only; the code checks the order in the open block only.
module nand_host_ctrl #(
  parameter int PAGE_BYTES = nand_host_pkg::PAGE_BYTES,
  parameter int TWB_TICKS  = nand_host_pkg::TWB_TICKS
) (
  // clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  // request port
  input  wire logic       i_cmd_valid,
  input  wire logic [1:0] i_cmd_op,
  input  wire logic [9:0] i_cmd_blk,
  input  wire logic [5:0] i_cmd_page,
  input  wire logic [11:0] i_cmd_col,
  output logic            o_cmd_ready,
  output logic            o_done,
  output logic            o_fail,
  output logic            o_refused,
  output logic            o_marked_bad,
  output logic [9:0]      o_spare_blk,
  output logic            o_low_good,
  // write data
  input  wire logic       i_wr_valid,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_wr_last,
  output logic            o_wr_ready,
  // read data
  output logic            o_rd_valid,
  output logic [7:0]      o_rd_data,
  // correction status from the ecc engine
  input  wire logic       i_ecc_valid,
  input  wire logic [3:0] i_ecc_bits,
  input  wire logic       i_ecc_uncorr,
  output logic            o_rewrite_advise,
  output logic            o_uncorrectable,
  // flash pins
  output logic            o_ce_n,
  output logic            o_cle,
  output logic            o_ale,
  output logic            o_we_n,
  output logic            o_re_n,
  output logic            o_wp_n,
  input  wire logic [7:0] i_dq,
  output logic [7:0]      o_dq,
  output logic            o_dq_oe_n,
  input  wire logic       i_ready_busy_n
);
  typedef enum logic [8:0] {
    S_IDLE  = 9'h001, S_CMD1 = 9'h002, S_ADDR = 9'h004, S_WDATA = 9'h008, S_CMD2 = 9'h010,
    S_BUSY  = 9'h020, S_STCMD = 9'h040, S_RDATA = 9'h080, S_DONE = 9'h100
  } state_e;
  typedef enum logic [2:0] {P_PREP = 3'h1, P_ARMED = 3'h2, P_LOW = 3'h4} phase_e;

  function automatic logic [7:0] addr_byte(input logic [1:0] op, input logic [11:0] idx,
                                           input logic [11:0] col, input logic [15:0] row);
    logic [7:0] b;
    b = 8'h00;
    if (op == nand_host_pkg::OP_ERASE)
      b = (idx == 12'h000) ? row[7:0] : row[15:8];
    else
      unique case (idx[1:0])
        2'h0: b = col[7:0];
        2'h1: b = {4'h0, col[11:8]};
        2'h2: b = row[7:0];
        default: b = row[15:8];
      endcase
    return b;
  endfunction

  logic tick;
  bbt_if bbt ();
  strobe_divider u_div (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .o_tick(tick));
  bad_block_table u_bbt (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .bbt(bbt));

  // device inputs (data and ready/busy) pass two flops
  logic [7:0] dq_s1_q, dq_s2_q;
  logic       rb_s1_q, rb_s2_q;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
      rb_s1_q <= 1'b0;
      rb_s2_q <= 1'b0;
    end else begin
      dq_s1_q <= i_dq;
      dq_s2_q <= dq_s1_q;
      rb_s1_q <= i_ready_busy_n;
      rb_s2_q <= rb_s1_q;
    end
  end

  state_e      state_q, state_d;
  phase_e      ph_q, ph_d;
  logic [1:0]  op_q, op_d;
  logic [9:0]  blk_q, blk_d;
  logic [5:0]  page_q, page_d;
  logic [11:0] col_q, col_d;
  logic [11:0] cnt_q, cnt_d;
  logic        pad_q, pad_d;
  logic        stat_q, stat_d;
  logic [9:0]  open_blk_q, open_blk_d;
  logic [5:0]  open_page_q, open_page_d;
  logic [2:0]  part_q, part_d;
  logic        open_q, open_d;
  logic        ce_n_q, ce_n_d, cle_q, cle_d, ale_q, ale_d, we_n_q, we_n_d, re_n_q, re_n_d;
  logic        wp_n_q, wp_n_d, oe_n_q, oe_n_d;
  logic [7:0]  dq_q, dq_d, rd_q, rd_d;
  logic        rdv_q, rdv_d, done_q, done_d, fail_q, fail_d, ref_q, ref_d, mk_q, mk_d;
  logic        wrr_q, wrr_d, rdy_q, rdy_d;
  logic        mark, refuse, last_addr, last_byte;
  logic [9:0]  mark_blk;
  logic [7:0]  cmd_byte;

  assign bbt.chk_blk   = i_cmd_blk;
  assign bbt.mark      = mark;
  assign bbt.mark_blk  = mark_blk;
  assign bbt.spare_req = mark;

  always_comb begin
    state_d = state_q; ph_d = ph_q; op_d = op_q; blk_d = blk_q; page_d = page_q;
    col_d = col_q; cnt_d = cnt_q; pad_d = pad_q; stat_d = stat_q;
    open_blk_d = open_blk_q; open_page_d = open_page_q; part_d = part_q; open_d = open_q;
    ce_n_d = ce_n_q; cle_d = cle_q; ale_d = ale_q; we_n_d = we_n_q; re_n_d = re_n_q;
    wp_n_d = wp_n_q; oe_n_d = oe_n_q; dq_d = dq_q; rd_d = rd_q; wrr_d = 1'b0;
    rdv_d = 1'b0; done_d = 1'b0; fail_d = 1'b0; ref_d = 1'b0; mk_d = 1'b0;
    mark = 1'b0; mark_blk = blk_q; rdy_d = 1'b0;
    refuse = 1'b0;
    last_addr = (cnt_q == ((op_q == nand_host_pkg::OP_ERASE) ?
                           12'(nand_host_pkg::ADDR_ERASE - 1) : 12'(nand_host_pkg::ADDR_PAGE - 1)));
    last_byte = (cnt_q == 12'(PAGE_BYTES - 1));
    unique case (op_q)
      nand_host_pkg::OP_PROG:  cmd_byte = stat_q ? nand_host_pkg::CMD_STATUS :
                                          (state_q == S_CMD1) ? nand_host_pkg::CMD_PROG1 :
                                          nand_host_pkg::CMD_PROG2;
      nand_host_pkg::OP_ERASE: cmd_byte = stat_q ? nand_host_pkg::CMD_STATUS :
                                          (state_q == S_CMD1) ? nand_host_pkg::CMD_ERASE1 :
                                          nand_host_pkg::CMD_ERASE2;
      default:                 cmd_byte = (state_q == S_CMD1) ? nand_host_pkg::CMD_READ1 :
                                          nand_host_pkg::CMD_READ2;
    endcase
    unique case (state_q)
      S_IDLE: begin
        rdy_d = 1'b1;
        if (i_cmd_valid && rdy_q) begin
          rdy_d = 1'b0;
          // bad blocks stay closed; scans allowed
          if (i_cmd_op != 2'(nand_host_pkg::OP_SCAN) && bbt.chk_bad) refuse = 1'b1;
          // page order and partial budget, open block only
          if (i_cmd_op == 2'(nand_host_pkg::OP_PROG) && open_q && i_cmd_blk == open_blk_q &&
              (i_cmd_page < open_page_q ||
               (i_cmd_page == open_page_q && part_q == 3'(nand_host_pkg::MAX_PARTIAL))))
            refuse = 1'b1;
          if (refuse) begin
            ref_d = 1'b1;
          end else begin
            op_d = i_cmd_op; blk_d = i_cmd_blk; page_d = i_cmd_page;
            col_d = (i_cmd_op == 2'(nand_host_pkg::OP_SCAN)) ?
                    12'(nand_host_pkg::MARK_COL) : i_cmd_col;
            cnt_d = 12'h000; pad_d = 1'b0; stat_d = 1'b0;
            ce_n_d = 1'b0;
            // protect is lifted only around program and erase
            wp_n_d = (i_cmd_op == 2'(nand_host_pkg::OP_PROG) ||
                      i_cmd_op == 2'(nand_host_pkg::OP_ERASE));
            state_d = S_CMD1; ph_d = P_PREP;
          end
        end
      end
      S_CMD1, S_CMD2, S_STCMD, S_ADDR, S_WDATA: begin
        unique case (ph_q)
          P_PREP: begin
            oe_n_d = 1'b0;
            cle_d = (state_q != S_ADDR && state_q != S_WDATA);
            ale_d = (state_q == S_ADDR);
            if (state_q == S_ADDR) begin
              dq_d = addr_byte(op_q, cnt_q, col_q, {blk_q, page_d});
              ph_d = P_ARMED;
            end else if (state_q == S_WDATA) begin
              // page tail is padded with ones
              if (pad_q) begin
                dq_d = nand_host_pkg::FILL_BYTE;
                ph_d = P_ARMED;
              end else if (i_wr_valid && wrr_q) begin
                dq_d = i_wr_data;
                pad_d = i_wr_last;
                ph_d = P_ARMED;
              end else begin
                wrr_d = 1'b1;
              end
            end else begin
              dq_d = cmd_byte;
              ph_d = P_ARMED;
            end
          end
          P_ARMED: if (tick) begin
            we_n_d = 1'b0;
            ph_d = P_LOW;
          end
          default: if (tick) begin
            we_n_d = 1'b1;
            ph_d = P_PREP;
            cnt_d = cnt_q + 12'h001;
            unique case (state_q)
              S_CMD1: begin
                state_d = S_ADDR;
                cnt_d = 12'h000;
              end
              S_ADDR: if (last_addr) begin
                state_d = (op_q == nand_host_pkg::OP_PROG) ? S_WDATA : S_CMD2;
                cnt_d = 12'h000;
              end
              S_WDATA: if (last_byte) begin
                state_d = S_CMD2;
              end
              S_STCMD: begin
                state_d = S_RDATA;
                cnt_d = 12'h000;
              end
              default: begin
                state_d = S_BUSY;
                cnt_d = 12'h000;
              end
            endcase
          end
        endcase
      end
      S_BUSY: begin
        cle_d = 1'b0;
        ale_d = 1'b0;
        oe_n_d = 1'b1;
        if (tick && cnt_q != 12'(TWB_TICKS)) cnt_d = cnt_q + 12'h001;
        // status is untrusted while busy
        if (cnt_q == 12'(TWB_TICKS) && rb_s2_q) begin
          cnt_d = 12'h000;
          ph_d = P_PREP;
          if (op_q == nand_host_pkg::OP_PROG || op_q == nand_host_pkg::OP_ERASE) begin
            stat_d = 1'b1;
            state_d = S_STCMD;
          end else begin
            state_d = S_RDATA;
            ph_d = P_ARMED;
          end
        end
      end
      S_RDATA: begin
        oe_n_d = 1'b1;
        cle_d = 1'b0;
        if (ph_q == P_PREP) ph_d = P_ARMED;
        else if (ph_q == P_ARMED && tick) begin
          re_n_d = 1'b0;
          ph_d = P_LOW;
        end else if (ph_q == P_LOW && tick) begin
          re_n_d = 1'b1;
          ph_d = P_ARMED;
          rd_d = dq_s2_q;
          cnt_d = cnt_q + 12'h001;
          if (stat_q) begin
            fail_d = dq_s2_q[nand_host_pkg::STAT_FAIL_BIT];
            mark = dq_s2_q[nand_host_pkg::STAT_FAIL_BIT];
            state_d = S_DONE;
          end else if (op_q == nand_host_pkg::OP_SCAN) begin
            mark = (dq_s2_q == nand_host_pkg::BAD_MARK);
            fail_d = mark;
            state_d = S_DONE;
          end else begin
            rdv_d = 1'b1;
            if (cnt_q == 12'(PAGE_BYTES) - col_q - 12'h001) state_d = S_DONE;
          end
          mk_d = mark;
        end
      end
      default: begin
        // wrap-up: open block, protect, chip enable
        if (op_q == nand_host_pkg::OP_PROG) begin
          if (open_q && open_blk_q == blk_q && open_page_q == page_q) begin
            part_d = part_q + 3'h1;
          end else begin
            open_blk_d = blk_q;
            open_page_d = page_q;
            part_d = 3'h1;
          end
          open_d = !fail_q;
        end else if (op_q == nand_host_pkg::OP_ERASE && open_blk_q == blk_q) begin
          open_d = 1'b0;
        end
        wp_n_d = 1'b0;
        ce_n_d = 1'b1;
        stat_d = 1'b0;
        done_d = 1'b1;
        fail_d = fail_q;
        state_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_q <= S_IDLE; ph_q <= P_PREP; op_q <= 2'h0; blk_q <= 10'h000; page_q <= 6'h00;
      col_q <= 12'h000; cnt_q <= 12'h000; pad_q <= 1'b0; stat_q <= 1'b0;
      open_blk_q <= 10'h000; open_page_q <= 6'h00; part_q <= 3'h0; open_q <= 1'b0;
      ce_n_q <= 1'b1; cle_q <= 1'b0; ale_q <= 1'b0; we_n_q <= 1'b1; re_n_q <= 1'b1;
      wp_n_q <= 1'b0; oe_n_q <= 1'b1; dq_q <= 8'h00; rd_q <= 8'h00; rdv_q <= 1'b0;
      done_q <= 1'b0; fail_q <= 1'b0; ref_q <= 1'b0; mk_q <= 1'b0; wrr_q <= 1'b0;
      rdy_q <= 1'b0;
    end else begin
      state_q <= state_d; ph_q <= ph_d; op_q <= op_d; blk_q <= blk_d; page_q <= page_d;
      col_q <= col_d; cnt_q <= cnt_d; pad_q <= pad_d; stat_q <= stat_d;
      open_blk_q <= open_blk_d; open_page_q <= open_page_d; part_q <= part_d;
      open_q <= open_d; ce_n_q <= ce_n_d; cle_q <= cle_d; ale_q <= ale_d;
      we_n_q <= we_n_d; re_n_q <= re_n_d; wp_n_q <= wp_n_d; oe_n_q <= oe_n_d;
      dq_q <= dq_d; rd_q <= rd_d; rdv_q <= rdv_d; done_q <= done_d; fail_q <= fail_d;
      ref_q <= ref_d; mk_q <= mk_d; wrr_q <= wrr_d; rdy_q <= rdy_d;
    end
  end

  // warn early so data is rewritten before loss
  logic adv_q, adv_d, unc_q, unc_d, low_q, low_d;
  logic [9:0] spare_q, spare_d;
  always_comb begin
    adv_d = i_ecc_valid && i_ecc_bits >= 4'(nand_host_pkg::ECC_WARN);
    unc_d = i_ecc_valid && (i_ecc_uncorr || i_ecc_bits > 4'(nand_host_pkg::ECC_MAX_BITS));
    low_d = bbt.bad_cnt > 11'(nand_host_pkg::BLOCKS - nand_host_pkg::MIN_GOOD);
    spare_d = bbt.spare_ok ? bbt.spare_blk : spare_q;
  end
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      adv_q <= 1'b0;
      unc_q <= 1'b0;
      low_q <= 1'b0;
      spare_q <= 10'h000;
    end else begin
      adv_q <= adv_d;
      unc_q <= unc_d;
      low_q <= low_d;
      spare_q <= spare_d;
    end
  end

  assign o_cmd_ready = rdy_q;
  assign o_done = done_q;
  assign o_fail = fail_q && done_q;
  assign o_refused = ref_q;
  assign o_marked_bad = mk_q;
  assign o_spare_blk = spare_q;
  assign o_low_good = low_q;
  assign o_wr_ready = wrr_q;
  assign o_rd_valid = rdv_q;
  assign o_rd_data = rd_q;
  assign o_rewrite_advise = adv_q;
  assign o_uncorrectable = unc_q;
  assign o_ce_n = ce_n_q;
  assign o_cle = cle_q;
  assign o_ale = ale_q;
  assign o_we_n = we_n_q;
  assign o_re_n = re_n_q;
  assign o_wp_n = wp_n_q;
  assign o_dq = dq_q;
  assign o_dq_oe_n = oe_n_q;
endmodule // nand_host_ctrl

// ==== tb/nand_host_checker.sv ====
`timescale 1ns/1ps
module nand_host_checker (
  // clock and reset
  input wire logic       i_mclk,
  input wire logic       i_rst_n,
  // request port
  input wire logic       i_cmd_valid,
  input logic            o_cmd_ready,
  input logic            o_done,
  input logic            o_fail,
  input logic            o_refused,
  // flash pins
  input logic            o_ce_n,
  input logic            o_cle,
  input logic            o_ale,
  input logic            o_we_n,
  input logic            o_re_n,
  input logic            o_wp_n,
  input logic [7:0]      o_dq,
  input logic            o_dq_oe_n,
  input wire logic       i_ready_busy_n
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  logic [2:0] addr_cnt_q;

  // a command latch restarts the count
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || o_cle) begin
      addr_cnt_q <= 3'h0;
    end else if (o_ale && $fell(o_we_n)) begin
      addr_cnt_q <= addr_cnt_q + 3'h1;
    end
  end

  sequence s_cmd(logic [7:0] code);
    o_cle && $fell(o_we_n) && o_dq == code;
  endsequence
  sequence s_confirm;
    s_cmd(nand_host_pkg::CMD_PROG2) or s_cmd(nand_host_pkg::CMD_ERASE2);
  endsequence

  AST_WP_IDLE: assert property (o_cmd_ready |-> !o_wp_n)
    else $error("protect off in idle");
  AST_WP_CONFIRM: assert property (s_confirm |-> o_wp_n)
    else $error("confirm while protected");
  AST_ADDR_MAX: assert property (addr_cnt_q <= 3'h4)
    else $error("fifth address cycle");
  AST_REFUSE_TAKE: assert property (o_refused |-> o_ce_n && $past(i_cmd_valid && o_cmd_ready))
    else $error("stray refusal");
  AST_STATUS_AFTER: assert property (s_confirm |-> ##[1:900] s_cmd(nand_host_pkg::CMD_STATUS))
    else $error("no status after confirm");
  AST_READY_FIRST: assert property (s_cmd(nand_host_pkg::CMD_STATUS) |-> $past(i_ready_busy_n, 2))
    else $error("status while busy");
  AST_FAIL_DONE: assert property (o_fail |-> o_done)
    else $error("fail without done");
  AST_READ_TURN: assert property (!o_re_n |-> o_dq_oe_n)
    else $error("host drives during read");
endmodule // nand_host_checker

bind nand_host_ctrl nand_host_checker i_chk (
  .i_mclk, .i_rst_n, .i_cmd_valid, .o_cmd_ready, .o_done, .o_fail, .o_refused,
  .o_ce_n, .o_cle, .o_ale, .o_we_n, .o_re_n, .o_wp_n, .o_dq, .o_dq_oe_n, .i_ready_busy_n
);

// ==== tb/nand_dev_model.sv ====
`timescale 1ns/1ps
module nand_dev_model #(
  parameter int BUSY_CYC = 40
) (
  // clock
  input  wire logic       i_mclk,
  // flash pins
  input  wire logic       i_ce_n,
  input  wire logic       i_cle,
  input  wire logic       i_ale,
  input  wire logic       i_we_n,
  input  wire logic       i_re_n,
  input  wire logic       i_wp_n,
  input  wire logic [7:0] i_dq,
  output logic [7:0]      o_dq,
  output logic            o_ready_busy_n = 1'b1,
  // scenario control
  input  wire logic       i_fail_next,
  input  wire logic [9:0] i_bad_blk
);
  logic [7:0]  mem [logic [27:0]];
  logic [7:0]  pbuf [int];
  logic [7:0]  adr [4];
  logic [7:0]  cmd = 8'hFF;
  logic [7:0]  dout = 8'hFF;
  logic        we_q = 1'b1;
  logic        re_q = 1'b1;
  logic        fail_q = 1'b0;
  logic [15:0] row;
  int          acnt, alast, wr_cnt, rcol, busy;
  int          erase_cnt [1024];

  // released bus shows inverse data
  assign o_dq = (!i_ce_n && !i_re_n) ? dout : ~dout;

  always @(posedge i_mclk) begin
    we_q <= i_we_n;
    re_q <= i_re_n;
    busy = (busy > 0 && (i_wp_n || cmd == nand_host_pkg::CMD_READ2)) ? busy - 1 : 0;
    if (!i_ce_n && !i_we_n && we_q) begin
      if (i_cle) begin
        cmd = i_dq;
        if (acnt > 0) alast = acnt;
        acnt = 0;
        if (cmd == nand_host_pkg::CMD_PROG1) begin
          wr_cnt = 0;
          pbuf.delete();
        end
        row = (cmd == nand_host_pkg::CMD_ERASE2) ? {adr[1], adr[0]} : {adr[3], adr[2]};
        rcol = {adr[1][3:0], adr[0]};
        if (cmd inside {nand_host_pkg::CMD_PROG2, nand_host_pkg::CMD_ERASE2}) begin
          busy = BUSY_CYC;
          fail_q = i_fail_next || !i_wp_n;
          if (i_wp_n && !i_fail_next) begin
            if (cmd == nand_host_pkg::CMD_ERASE2) begin
              erase_cnt[row[15:6]]++;
              foreach (mem[k]) if (k[27:18] == row[15:6]) mem[k] = 8'hFF;
            end else begin
              foreach (pbuf[k]) mem[{row, k[11:0]}] = pbuf[k];
            end
          end
        end
        if (cmd == nand_host_pkg::CMD_READ2) busy = BUSY_CYC;
      end else if (i_ale) begin
        if (acnt < 4) adr[acnt] = i_dq;
        acnt++;
      end else if (cmd == nand_host_pkg::CMD_PROG1) begin
        pbuf[{adr[1][3:0], adr[0]} + wr_cnt] = i_dq;
        wr_cnt++;
      end
    end
    if (!i_ce_n && !i_re_n && re_q) begin
      if (cmd == nand_host_pkg::CMD_STATUS) begin
        dout <= {i_wp_n, busy == 0, busy == 0, 3'h0, 1'b0, fail_q};
      end else if (row[15:6] == i_bad_blk && rcol == nand_host_pkg::MARK_COL) begin
        dout <= nand_host_pkg::BAD_MARK;
      end else begin
        dout <= mem.exists({row, rcol[11:0]}) ? mem[{row, rcol[11:0]}] : 8'hFF;
      end
    end
    if (i_re_n && !re_q && cmd != nand_host_pkg::CMD_STATUS) rcol++;
    o_ready_busy_n <= (busy == 0);
  end
endmodule // nand_dev_model

// ==== tb/nand_host_ctrl_tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("BAD %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module nand_host_ctrl_tb;
  localparam int PB = 16;
  logic        i_mclk = 1'b0;
  logic        i_rst_n, i_cmd_valid, i_wr_valid, i_wr_last, i_ecc_valid, i_ecc_uncorr;
  logic        fail_next, i_ready_busy_n;
  logic [1:0]  i_cmd_op;
  logic [9:0]  i_cmd_blk, o_spare_blk;
  logic [5:0]  i_cmd_page;
  logic [11:0] i_cmd_col;
  logic [3:0]  i_ecc_bits;
  logic [7:0]  i_wr_data, i_dq, o_dq, o_rd_data, dev_dq;
  logic        o_cmd_ready, o_done, o_fail, o_refused, o_marked_bad, o_low_good;
  logic        o_wr_ready, o_rd_valid, o_rewrite_advise, o_uncorrectable;
  logic        o_ce_n, o_cle, o_ale, o_we_n, o_re_n, o_wp_n, o_dq_oe_n;
  logic        got_done, got_fail, got_ref, got_mark;
  logic [7:0]  rdq [$];
  int          error_cnt, comparisons;

  assign i_dq = o_dq_oe_n ? dev_dq : o_dq;
  always #4 i_mclk = ~i_mclk;

  nand_host_ctrl #(.PAGE_BYTES(PB), .TWB_TICKS(4)) i_dut (
    .i_mclk, .i_rst_n, .i_cmd_valid, .i_cmd_op, .i_cmd_blk, .i_cmd_page, .i_cmd_col,
    .o_cmd_ready, .o_done, .o_fail, .o_refused, .o_marked_bad, .o_spare_blk, .o_low_good,
    .i_wr_valid, .i_wr_data, .i_wr_last, .o_wr_ready, .o_rd_valid, .o_rd_data,
    .i_ecc_valid, .i_ecc_bits, .i_ecc_uncorr, .o_rewrite_advise, .o_uncorrectable,
    .o_ce_n, .o_cle, .o_ale, .o_we_n, .o_re_n, .o_wp_n, .i_dq, .o_dq, .o_dq_oe_n,
    .i_ready_busy_n);
  nand_dev_model #(.BUSY_CYC(40)) i_dev (
    .i_mclk(i_mclk), .i_ce_n(o_ce_n), .i_cle(o_cle), .i_ale(o_ale), .i_we_n(o_we_n),
    .i_re_n(o_re_n), .i_wp_n(o_wp_n), .i_dq(i_dq), .o_dq(dev_dq),
    .o_ready_busy_n(i_ready_busy_n), .i_fail_next(fail_next), .i_bad_blk(10'h005));

  task automatic final_report;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // holds request until taken, one byte per ready
  task automatic do_op(input logic [1:0] op, input int blk, input int pg, input int n);
    int i;
    int k;
    i = 0;
    {got_done, got_fail, got_ref, got_mark} = 4'h0;
    rdq.delete();
    i_cmd_valid <= 1'b1;
    {i_cmd_op, i_cmd_blk, i_cmd_page} <= {op, 10'(blk), 6'(pg)};
    i_wr_valid <= (n > 0);
    i_wr_data <= 8'hA0;
    i_wr_last <= (n == 1);
    for (k = 0; k < 5000; k++) begin
      @(posedge i_mclk);
      if (i_cmd_valid && o_cmd_ready) i_cmd_valid <= 1'b0;
      if (i_wr_valid && o_wr_ready) begin
        i++;
        i_wr_valid <= (i < n);
        i_wr_data <= 8'hA0 + 8'(i);
        i_wr_last <= (i == n - 1);
      end
      if (o_rd_valid) rdq.push_back(o_rd_data);
      {got_done, got_fail, got_ref, got_mark} |= {o_done, o_fail, o_refused, o_marked_bad};
      if (o_done || o_refused) break;
    end
    if (k == 5000) begin
      error_cnt++;
      $display("BAD op_end expected done seen none");
      final_report();
    end
    i_wr_valid <= 1'b0;
    @(posedge i_mclk);
  endtask

  task automatic t_scan;
    do_op(nand_host_pkg::OP_SCAN, 5, 0, 0);
    `CHK("scan_bad", 1'b1, got_fail)
    do_op(nand_host_pkg::OP_SCAN, 6, 0, 0);
    `CHK("scan_good", 2'b10, {got_done, got_fail})
    do_op(nand_host_pkg::OP_ERASE, 5, 0, 0);
    `CHK("erase_bad_refused", 1'b1, got_ref)
    `CHK("bad_erase_count", 0, i_dev.erase_cnt[5])
  endtask

  task automatic t_program;
    int j;
    for (j = 0; j < 5; j++) begin
      do_op(nand_host_pkg::OP_PROG, 6, 0, 3);
      `CHK("partial_refused", j == 4, got_ref)
    end
    `CHK("addr_cycles", 4, i_dev.alast)
    `CHK("bytes_written", PB, i_dev.wr_cnt)
    `CHK("pad_byte", 8'hFF, i_dev.mem[{10'h006, 6'h00, 12'(PB - 1)}])
    do_op(nand_host_pkg::OP_PROG, 6, 1, 2);
    `CHK("next_page", 1'b1, got_done)
    do_op(nand_host_pkg::OP_PROG, 6, 0, 2);
    `CHK("lower_page_refused", 1'b1, got_ref)
    `CHK("protect_restored", 1'b0, o_wp_n)
  endtask

  task automatic t_fail(input logic [1:0] op, input int blk);
    fail_next <= 1'b1;
    do_op(op, blk, 0, 2);
    fail_next <= 1'b0;
    `CHK("status_fail", 2'b11, {got_fail, got_mark})
    `CHK("spare_elsewhere", 1'b1, o_spare_blk != 10'(blk))
    do_op(nand_host_pkg::OP_READ, blk, 0, 0);
    `CHK("retired_refused", 1'b1, got_ref)
  endtask

  task automatic t_read_ecc;
    int j;
    logic [3:0] bits [5] = '{4'h5, 4'h6, 4'h8, 4'h9, 4'h2};
    do_op(nand_host_pkg::OP_READ, 6, 0, 0);
    `CHK("read_len", PB, rdq.size())
    for (j = 0; j < PB; j++) `CHK("read_byte", (j < 3) ? 8'hA0 + 8'(j) : 8'hFF, rdq[j])
    for (j = 0; j < 5; j++) begin
      i_ecc_valid <= 1'b1;
      i_ecc_bits <= bits[j];
      i_ecc_uncorr <= (j == 4);
      @(posedge i_mclk);
      i_ecc_valid <= 1'b0;
      @(posedge i_mclk);
      `CHK("advise", bits[j] >= 4'h6, o_rewrite_advise)
      `CHK("uncorrectable", j >= 3, o_uncorrectable)
      `CHK("read_marks_bad", 1'b0, o_marked_bad)
    end
  endtask

  // push the bad count past the margin
  task automatic t_low_good;
    int b;
    `CHK("few_bad", 1'b0, o_low_good)
    fail_next <= 1'b1;
    for (b = 10; b < 30; b++) do_op(nand_host_pkg::OP_ERASE, b, 0, 0);
    fail_next <= 1'b0;
    @(posedge i_mclk);
    `CHK("many_bad", 1'b1, o_low_good)
  endtask

  initial begin
    {i_rst_n, i_cmd_valid, i_wr_valid, i_wr_last, i_ecc_valid, i_ecc_uncorr, fail_next} = '0;
    {i_cmd_op, i_cmd_blk, i_cmd_page, i_cmd_col, i_wr_data, i_ecc_bits} = '0;
    error_cnt = 0;
    comparisons = 0;
    repeat (5) @(posedge i_mclk);
    `CHK("reset_pins", 2'b01, {o_wp_n, o_ce_n})
    i_rst_n <= 1'b1;
    t_scan();
    t_program();
    t_fail(nand_host_pkg::OP_ERASE, 7);
    t_fail(nand_host_pkg::OP_PROG, 8);
    t_read_ecc();
    t_low_good();
    final_report();
  end
endmodule // nand_host_ctrl_tb
